/* core/colour_byte_memory.sv */
// Colour byte store with one write port and two registered read ports.
`timescale 1ns/1ps
module colour_byte_memory #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int ADDR_W = 4
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic wr_en, // Write strobe.
  input wire logic [ADDR_W-1:0] wr_index, // Write index.
  input wire logic [WIDTH-1:0] wr_data, // Write data.
  input wire logic [ADDR_W-1:0] host_index, // Register read index.
  output logic [WIDTH-1:0] host_rdata, // Register read data.
  input wire logic [ADDR_W-1:0] pat_index, // Pattern read index.
  output logic [WIDTH-1:0] pat_rdata // Pattern read data.
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= WIDTH'(pgen_pkg::COLOUR_RESET[i]);
      end
    end else if (wr_en) begin
      mem[wr_index] <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Read ports
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      host_rdata <= '0;
      pat_rdata <= '0;
    end else begin
      host_rdata <= mem[host_index];
      pat_rdata <= mem[pat_index];
    end
  end

endmodule

/* core/csi2_test_pattern_generator.sv */
// Test pattern generator building frames of packets from its register page.
`timescale 1ns/1ps
// Summary of operation
// - Config bit 7 picks colour bars (0) or fixed colour (1); resets 0.
// - Config bits 5:4 give one, two, four or eight bars per line.
// - Config bits 3:0 give fixed colour block size, 1 to 15, with 0 taken as 1.
// - Channel bits 7:6 go into the virtual channel of every packet.
// - Type bits 5:0 go into the packet data type; reset 0x24.
// - Active line length in bytes from two bytes, 1920 by default.
// - Bar width applies to all bars but the last, which takes the rest.
// - Active lines per frame from two bytes, 480 by default.
// - Total lines per frame including blanking, from two bytes.
// - Line period in 10 ns units from two bytes, 31.75 us default.
// - Control bit 0 starts the generator when set, stops it when clear.
// - Back and front porch give blank lines around the active lines.
// - Colour bytes feed bar n or byte n of the fixed pattern.
module csi2_test_pattern_generator (
  input wire logic clk_sys, // System clock, 100 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic [7:0] reg_addr, // Indirect page offset.
  input wire logic reg_wr, // Write strobe.
  input wire logic [7:0] reg_wdata, // Write data.
  input wire logic reg_rd, // Read strobe.
  output logic [7:0] reg_rdata, // Read data.
  output logic reg_rvalid, // Read data valid pulse.
  output logic pkt_valid, // Packet header pulse.
  output logic pkt_short, // Header is a short packet.
  output logic [7:0] pkt_data_id, // Channel and data type.
  output logic [15:0] pkt_word_count, // Payload byte count.
  output logic byte_valid, // Payload byte valid.
  output logic [7:0] byte_data, // Payload byte.
  output logic byte_last, // Last payload byte of a line.
  output logic generator_active // Generator running.
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] join16(input logic [7:0] hi, input logic [7:0] lo);
    join16 = {hi, lo};
  endfunction

  // ----------------------------------------------------------------
  // Register page
  // ----------------------------------------------------------------
  logic [7:0] page [16];

  wire page_hit = (reg_addr[7:4] == pgen_pkg::CONTROL_PAGE) && (reg_addr[3:0] != 4'h0);
  wire colour_hit = (reg_addr[7:4] == pgen_pkg::COLOUR_PAGE);
  wire page_write = reg_wr && page_hit;
  wire colour_write = reg_wr && colour_hit;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < 16; i++) begin
        page[i] <= pgen_pkg::PAGE_RESET[i];
      end
    end else if (page_write) begin
      page[reg_addr[3:0]] <= reg_wdata;
    end
  end

  wire [7:0] control_byte = page[pgen_pkg::IDX_CONTROL];
  wire [7:0] config_byte = page[pgen_pkg::IDX_PATTERN_CONFIG];
  wire [7:0] channel_byte = page[pgen_pkg::IDX_CHANNEL_TYPE];
  wire generator_on = control_byte[pgen_pkg::GEN_ON_BIT];
  wire fixed_colour_select = config_byte[pgen_pkg::FIXED_COLOUR_BIT];
  wire [1:0] bar_count_code = config_byte[pgen_pkg::BAR_COUNT_HI:pgen_pkg::BAR_COUNT_LO];
  wire [3:0] block_size = config_byte[pgen_pkg::BLOCK_SIZE_HI:pgen_pkg::BLOCK_SIZE_LO];
  wire [1:0] packet_virtual_channel = channel_byte[pgen_pkg::VC_HI:pgen_pkg::VC_LO];
  wire [5:0] packet_data_type = channel_byte[pgen_pkg::DT_HI:pgen_pkg::DT_LO];
  wire [15:0] active_line_bytes = join16(page[pgen_pkg::IDX_LINE_BYTES_HIGH],
    page[pgen_pkg::IDX_LINE_BYTES_LOW]);
  wire [15:0] bar_width_bytes = join16(page[pgen_pkg::IDX_BAR_WIDTH_HIGH],
    page[pgen_pkg::IDX_BAR_WIDTH_LOW]);
  wire [15:0] active_line_count = join16(page[pgen_pkg::IDX_ACTIVE_LINES_HIGH],
    page[pgen_pkg::IDX_ACTIVE_LINES_LOW]);
  wire [15:0] total_line_count = join16(page[pgen_pkg::IDX_TOTAL_LINES_HIGH],
    page[pgen_pkg::IDX_TOTAL_LINES_LOW]);
  wire [15:0] line_period_ticks = join16(page[pgen_pkg::IDX_LINE_PERIOD_HIGH],
    page[pgen_pkg::IDX_LINE_PERIOD_LOW]);
  wire [7:0] vertical_back_porch_lines = page[pgen_pkg::IDX_BACK_PORCH];
  wire [7:0] vertical_front_porch_lines = page[pgen_pkg::IDX_FRONT_PORCH];

  // ----------------------------------------------------------------
  // Read pipeline
  // ----------------------------------------------------------------
  logic rd_pend;
  logic rd_colour;
  logic [7:0] rd_page_value;
  logic [7:0] host_rdata;

  wire [7:0] page_read_value = page_hit ? page[reg_addr[3:0]] : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_pend <= 1'b0;
      rd_colour <= 1'b0;
      rd_page_value <= 8'h00;
      reg_rvalid <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      rd_pend <= reg_rd;
      rd_colour <= colour_hit;
      rd_page_value <= page_read_value;
      reg_rvalid <= rd_pend;
      if (rd_pend) begin
        reg_rdata <= rd_colour ? host_rdata : rd_page_value;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  wire [19:0] period_cycles = 20'(line_period_ticks) * 20'(pgen_pkg::TICK_CYCLES);
  wire [16:0] first_active = 17'(vertical_back_porch_lines) + 17'h0_0001;
  wire [16:0] active_end = first_active + 17'(active_line_count);
  wire [16:0] frame_end_line = active_end + 17'(vertical_front_porch_lines);
  wire [3:0] bar_limit = 4'((5'h01 << bar_count_code) - 5'h01);
  wire [3:0] block_limit = (block_size == 4'h0) ? 4'h0 : block_size - 4'h1;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  pgen_pkg::gen_state_t state;
  pgen_pkg::gen_state_t next_state;
  logic [19:0] line_timer;
  logic [19:0] next_line_timer;
  logic [15:0] line_index;
  logic [15:0] next_line_index;
  logic [15:0] byte_index;
  logic [15:0] next_byte_index;
  logic [15:0] bar_bytes;
  logic [15:0] next_bar_bytes;
  logic [3:0] bar_index;
  logic [3:0] next_bar_index;
  logic [3:0] block_index;
  logic [3:0] next_block_index;
  logic next_pkt_valid;
  logic next_pkt_short;
  logic [5:0] next_pkt_type;

  wire [16:0] line_wide = 17'(line_index);
  wire line_boundary = (line_timer == 20'h0_0000);
  wire period_done = (21'(line_timer) + 21'h00_0001) >= 21'(period_cycles);
  wire last_line = (line_index + 16'h0001) >= total_line_count;
  wire in_active = (line_wide >= first_active) && (line_wide < active_end);
  wire sending = (state == pgen_pkg::st_send);
  wire last_byte = (byte_index + 16'h0001) >= active_line_bytes;
  wire bar_done = (bar_bytes + 16'h0001) >= bar_width_bytes;
  wire [3:0] pattern_index = fixed_colour_select ? block_index : bar_index;

  always_comb begin
    next_state = state;
    next_line_timer = line_timer;
    next_line_index = line_index;
    next_byte_index = byte_index;
    next_bar_bytes = bar_bytes;
    next_bar_index = bar_index;
    next_block_index = block_index;
    next_pkt_valid = 1'b0;
    next_pkt_short = 1'b0;
    next_pkt_type = packet_data_type;
    case (state)
      pgen_pkg::st_off: begin
        next_line_timer = 20'h0_0000;
        next_line_index = 16'h0000;
        if (generator_on) begin
          next_state = pgen_pkg::st_wait;
        end
      end
      default: begin
        next_line_timer = period_done ? 20'h0_0000 : line_timer + 20'h0_0001;
        if (line_boundary) begin
          next_line_index = last_line ? 16'h0000 : line_index + 16'h0001;
        end
        if (sending) begin
          next_byte_index = byte_index + 16'h0001;
          if (bar_done && (bar_index != bar_limit)) begin
            next_bar_index = bar_index + 4'h1;
            next_bar_bytes = 16'h0000;
          end else begin
            next_bar_bytes = bar_bytes + 16'h0001;
          end
          next_block_index = (block_index >= block_limit) ? 4'h0 : block_index + 4'h1;
          if (last_byte) begin
            next_state = pgen_pkg::st_wait;
          end
        end else if (line_boundary) begin
          if (line_index == 16'h0000) begin
            next_pkt_valid = 1'b1;
            next_pkt_short = 1'b1;
            next_pkt_type = pgen_pkg::DT_FRAME_START;
          end else if (in_active) begin
            next_pkt_valid = 1'b1;
            next_byte_index = 16'h0000;
            next_bar_bytes = 16'h0000;
            next_bar_index = 4'h0;
            next_block_index = 4'h0;
            if (active_line_bytes != 16'h0000) begin
              next_state = pgen_pkg::st_send;
            end
          end else if (line_wide == frame_end_line) begin
            next_pkt_valid = 1'b1;
            next_pkt_short = 1'b1;
            next_pkt_type = pgen_pkg::DT_FRAME_END;
          end
        end
        if (!generator_on) begin
          next_state = pgen_pkg::st_off;
          next_pkt_valid = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= pgen_pkg::st_off;
      line_timer <= 20'h0_0000;
      line_index <= 16'h0000;
      byte_index <= 16'h0000;
      bar_bytes <= 16'h0000;
      bar_index <= 4'h0;
      block_index <= 4'h0;
    end else begin
      state <= next_state;
      line_timer <= next_line_timer;
      line_index <= next_line_index;
      byte_index <= next_byte_index;
      bar_bytes <= next_bar_bytes;
      bar_index <= next_bar_index;
      block_index <= next_block_index;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pkt_valid <= 1'b0;
      pkt_short <= 1'b0;
      pkt_data_id <= 8'h00;
      pkt_word_count <= 16'h0000;
      byte_valid <= 1'b0;
      byte_last <= 1'b0;
      generator_active <= 1'b0;
    end else begin
      pkt_valid <= next_pkt_valid;
      pkt_short <= next_pkt_short;
      if (next_pkt_valid) begin
        pkt_data_id <= {packet_virtual_channel, next_pkt_type};
        pkt_word_count <= next_pkt_short ? 16'h0000 : active_line_bytes;
      end
      byte_valid <= sending && generator_on;
      byte_last <= sending && generator_on && last_byte;
      generator_active <= (next_state != pgen_pkg::st_off);
    end
  end

  // ----------------------------------------------------------------
  // Colour bytes
  // ----------------------------------------------------------------
  colour_byte_memory #(
    .WIDTH(8),
    .DEPTH(16),
    .ADDR_W(4)
  ) colour_store (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(colour_write),
    .wr_index(reg_addr[3:0]),
    .wr_data(reg_wdata),
    .host_index(reg_addr[3:0]),
    .host_rdata(host_rdata),
    .pat_index(pattern_index),
    .pat_rdata(byte_data)
  );

endmodule

/* shared/pgen_pkg.sv */
// Constants, register layout and state encoding of the test pattern generator.
package pgen_pkg;

  // ----------------------------------------------------------------
  // Register page offsets (index within the indirect page) and page numbers
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_CONTROL = 4'h1;
  localparam logic [3:0] IDX_PATTERN_CONFIG = 4'h2;
  localparam logic [3:0] IDX_CHANNEL_TYPE = 4'h3;
  localparam logic [3:0] IDX_LINE_BYTES_HIGH = 4'h4;
  localparam logic [3:0] IDX_LINE_BYTES_LOW = 4'h5;
  localparam logic [3:0] IDX_BAR_WIDTH_HIGH = 4'h6;
  localparam logic [3:0] IDX_BAR_WIDTH_LOW = 4'h7;
  localparam logic [3:0] IDX_ACTIVE_LINES_HIGH = 4'h8;
  localparam logic [3:0] IDX_ACTIVE_LINES_LOW = 4'h9;
  localparam logic [3:0] IDX_TOTAL_LINES_HIGH = 4'ha;
  localparam logic [3:0] IDX_TOTAL_LINES_LOW = 4'hb;
  localparam logic [3:0] IDX_LINE_PERIOD_HIGH = 4'hc;
  localparam logic [3:0] IDX_LINE_PERIOD_LOW = 4'hd;
  localparam logic [3:0] IDX_BACK_PORCH = 4'he;
  localparam logic [3:0] IDX_FRONT_PORCH = 4'hf;
  localparam logic [3:0] COLOUR_PAGE = 4'h1;
  localparam logic [3:0] CONTROL_PAGE = 4'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GEN_ON_BIT = 0;
  localparam int FIXED_COLOUR_BIT = 7;
  localparam int BAR_COUNT_HI = 5;
  localparam int BAR_COUNT_LO = 4;
  localparam int BLOCK_SIZE_HI = 3;
  localparam int BLOCK_SIZE_LO = 0;
  localparam int VC_HI = 7;
  localparam int VC_LO = 6;
  localparam int DT_HI = 5;
  localparam int DT_LO = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PAGE_RESET [16] = '{
    8'h00, 8'h00, 8'h33, 8'h24, 8'h07, 8'h80, 8'h00, 8'hf0,
    8'h01, 8'he0, 8'h02, 8'h0d, 8'h0c, 8'h67, 8'h21, 8'h0a
  };
  localparam logic [7:0] COLOUR_RESET [16] = '{
    8'haa, 8'h33, 8'hf0, 8'h7f, 8'h55, 8'hcc, 8'h0f, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
  };

  // ----------------------------------------------------------------
  // Packet codes and timing
  // ----------------------------------------------------------------
  localparam logic [5:0] DT_FRAME_START = 6'h00;
  localparam logic [5:0] DT_FRAME_END = 6'h01;
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINE_TICK_NS = 10;
  localparam int TICK_CYCLES = (LINE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 20;

  // ----------------------------------------------------------------
  // Generator states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_off = 3'b001,
    st_wait = 3'b010,
    st_send = 3'b100
  } gen_state_t;

endpackage

/* verification/csi2_test_pattern_generator_tb.sv */
// Self-checking bench for the test pattern generator.
`timescale 1ns/1ps
module csi2_test_pattern_generator_tb;
  logic clk_sys, rst_n, reg_wr, reg_rd;
  logic [7:0] reg_addr, reg_wdata;
  logic [7:0] reg_rdata, pkt_data_id, byte_data;
  logic reg_rvalid, pkt_valid, pkt_short, byte_valid, byte_last, generator_active;
  logic [15:0] pkt_word_count;
  int n_fail, n_compared, cyc, seen;
  localparam logic [7:0] RESET_TAB [12] = '{8'h33, 8'h24, 8'h07, 8'h80, 8'h00, 8'hf0,
    8'h01, 8'he0, 8'h02, 8'h0d, 8'h0c, 8'h67};
  localparam logic [15:0] SETUP_TAB [12] = '{16'h0400, 16'h0510, 16'h0600, 16'h0702,
    16'h0800, 16'h0902, 16'h0a00, 16'h0b06, 16'h0c00, 16'h0d40, 16'h0e01, 16'h0f01};
  csi2_test_pattern_generator i_csi2_test_pattern_generator (.clk_sys, .rst_n, .reg_addr,
    .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .pkt_valid, .pkt_short,
    .pkt_data_id, .pkt_word_count, .byte_valid, .byte_data, .byte_last, .generator_active);
  packet_sink i_packet_sink (.clk_sys, .rst_n, .pkt_valid, .pkt_short, .pkt_data_id,
    .pkt_word_count, .byte_valid, .byte_data, .byte_last);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    int k;
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (reg_rvalid !== 1'b1 && k < 4);
    chk({7'h00, reg_rvalid, reg_rdata}, {8'h01, exp});
  endtask
  task automatic wait_ev();
    int k;
    k = 0;
    while (i_packet_sink.n_ev == seen && k < 400) begin
      @(negedge clk_sys);
      k++;
    end
    chk(16'(k < 400), 16'h0001);
    seen = seen + 1;
  endtask
  // Enables, checks frame start and the first long header, waits for its line end.
  task automatic run_line(input logic [7:0] id);
    seen = i_packet_sink.n_ev;
    wr(8'h01, 8'h01);
    wait_ev();
    chk({7'h00, i_packet_sink.hdr_short, i_packet_sink.hdr_id}, {8'h01, id[7:6], 6'h00});
    chk({15'h0000, generator_active}, 16'h0001);
    wait_ev();
    chk({7'h00, i_packet_sink.hdr_short, i_packet_sink.hdr_id}, {8'h00, id});
    chk(i_packet_sink.hdr_wc, 16'h0010);
    wait_ev();
    chk(16'(i_packet_sink.idx), 16'h0010);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic check_resets();
    chk({15'h0000, generator_active}, 16'h0000);
    rd_chk(8'h01, 8'h00);
    for (int a = 2; a < 14; a++) rd_chk(8'(a), RESET_TAB[a-2]);
    wr(8'h20, 8'h5a);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h16, 8'h0f);
    wr(8'h18, 8'h3c);
    rd_chk(8'h18, 8'h3c);
  endtask
  task automatic setup_small();
    for (int i = 0; i < 12; i++) wr(SETUP_TAB[i][15:8], SETUP_TAB[i][7:0]);
    rd_chk(8'h0d, 8'h40);
  endtask
  task automatic bar_lines();
    int b;
    for (int c = 0; c < 4; c++) begin
      wr(8'h02, {2'b00, c[1:0], 4'h3});
      run_line(8'h24);
      for (int i = 0; i < 16; i++) begin
        b = (i / 2 < (1 << c)) ? i / 2 : (1 << c) - 1;
        chk({8'h00, i_packet_sink.lb[i]}, {8'h00, pgen_pkg::COLOUR_RESET[b]});
      end
      wr(8'h01, 8'h00);
    end
  endtask
  task automatic fixed_colour();
    wr(8'h02, 8'h83);
    run_line(8'h24);
    for (int n = 0; n < 2; n++) begin
      for (int i = 0; i < 16; i++) chk({8'h00, i_packet_sink.lb[i]}, {8'h00, pgen_pkg::COLOUR_RESET[i % 3]});
      wait_ev();
      wait_ev();
    end
    wr(8'h01, 8'h00);
  endtask
  task automatic frame_timing();
    int t0;
    wr(8'h02, 8'h33);
    wr(8'h03, 8'haa);
    run_line(8'haa);
    t0 = i_packet_sink.hdr_cyc;
    wait_ev();
    chk(16'(i_packet_sink.hdr_cyc - t0), 16'h0040);
    wait_ev();
    wait_ev();
    chk({7'h00, i_packet_sink.hdr_short, i_packet_sink.hdr_id}, 16'h0181);
    chk(16'(i_packet_sink.hdr_cyc - t0), 16'h00c0);
    wait_ev();
    chk({7'h00, i_packet_sink.hdr_short, i_packet_sink.hdr_id}, 16'h0180);
    chk(16'(i_packet_sink.hdr_cyc - t0), 16'h0100);
    wr(8'h01, 8'h00);
  endtask
  task automatic stop_midline();
    int n;
    run_line(8'haa);
    wait_ev();
    repeat (3) @(negedge clk_sys);
    wr(8'h01, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk({14'h0000, generator_active, byte_valid}, 16'h0000);
    n = i_packet_sink.n_ev;
    repeat (300) @(negedge clk_sys);
    chk(16'(i_packet_sink.n_ev - n), 16'h0000);
  endtask
  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    n_fail = 0;
    n_compared = 0;
    seen = 0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    check_resets();
    setup_small();
    bar_lines();
    fixed_colour();
    frame_timing();
    stop_midline();
    tally_and_finish();
  end
endmodule
bind csi2_test_pattern_generator pgen_checker i_pgen_checker (.clk_sys, .rst_n, .reg_rd,
  .reg_rvalid, .pkt_valid, .pkt_short, .pkt_data_id, .pkt_word_count, .byte_valid,
  .byte_last, .generator_active);

/* verification/packet_sink.sv */
// Far-side model recording packet headers and the bytes of the latest line.
`timescale 1ns/1ps
module packet_sink (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic pkt_valid, // Header pulse.
  input wire logic pkt_short, // Short header.
  input wire logic [7:0] pkt_data_id, // Channel and type.
  input wire logic [15:0] pkt_word_count, // Payload byte count.
  input wire logic byte_valid, // Payload byte strobe.
  input wire logic [7:0] byte_data, // Payload byte.
  input wire logic byte_last // Last byte of a line.
);
  int n_ev;
  int idx;
  int cyc;
  int hdr_cyc;
  logic hdr_short;
  logic [7:0] hdr_id;
  logic [15:0] hdr_wc;
  logic [7:0] lb [64];
  // Each header and each line end counts as one event for the bench.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (!rst_n) begin
      n_ev <= 0;
      idx <= 0;
    end else begin
      if (pkt_valid) begin
        hdr_short <= pkt_short;
        hdr_id <= pkt_data_id;
        hdr_wc <= pkt_word_count;
        hdr_cyc <= cyc;
        idx <= 0;
      end
      if (byte_valid) begin
        lb[idx % 64] <= byte_data;
        idx <= idx + 1;
      end
      if (pkt_valid || byte_last) n_ev <= n_ev + 1;
    end
  end
endmodule

/* verification/pgen_checker.sv */
// Concurrent checks on the ports of the test pattern generator.
`timescale 1ns/1ps
module pgen_checker (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic reg_rd, // Read strobe.
  input wire logic reg_rvalid, // Read answer pulse.
  input wire logic pkt_valid, // Header pulse.
  input wire logic pkt_short, // Short header.
  input wire logic [7:0] pkt_data_id, // Channel and type.
  input wire logic [15:0] pkt_word_count, // Payload byte count.
  input wire logic byte_valid, // Payload byte strobe.
  input wire logic byte_last, // Last byte of a line.
  input wire logic generator_active // Generator running.
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [15:0] run_len;
  logic [15:0] wc_held;
  // Bytes seen since the last header, to compare with the announced count.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || pkt_valid) run_len <= 16'h0000;
    else if (byte_valid) run_len <= run_len + 16'h0001;
  end
  always_ff @(posedge clk_sys) begin
    if (pkt_valid && !pkt_short) wc_held <= pkt_word_count;
  end
  sequence long_hdr;
    pkt_valid && !pkt_short;
  endsequence
  sequence byte_start;
    byte_valid && !pkt_valid;
  endsequence
  rd_answer_a: assert property (reg_rd |-> ##2 reg_rvalid)
    else $error("read answer not two cycles after strobe");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd, 2))
    else $error("read answer without a read");
  hdr_bytes_a: assert property (long_hdr |=> byte_start)
    else $error("payload does not follow long header");
  line_len_a: assert property (byte_last |-> run_len + 16'h0001 == wc_held)
    else $error("payload length differs from word count");
  short_hdr_a: assert property (pkt_valid && pkt_short |->
    pkt_word_count == 16'h0000 && pkt_data_id[5:0] <= 6'h01)
    else $error("short header malformed");
  last_end_a: assert property (byte_last |-> byte_valid ##1 !byte_valid)
    else $error("line end not at payload end");
  pkt_pulse_a: assert property (pkt_valid |-> !byte_valid ##1 !pkt_valid)
    else $error("header pulse overlaps or stretches");
  off_quiet_a: assert property (!generator_active && !$past(generator_active) |->
    !byte_valid && !pkt_valid)
    else $error("traffic while stopped");
endmodule
